/* File: dv/bfs_host.sv */
// Host model: a classic Wishbone master that issues one register cycle at a time.
// Assumes the slave answers each request with a one-cycle acknowledge.
`timescale 1ns/10ps
module bfs_host (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  output logic             o_cyc,
  output logic             o_stb,
  output logic             o_we,
  output logic [7:0]       o_adr,
  output logic [3:0]       o_sel,
  output logic [31:0]      o_dat
);
  int n_tmo = 0;  // Requests that never got an answer

  initial
  begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we  = 1'b0;
    o_adr = 8'h00;
    o_sel = 4'h0;
    o_dat = 32'h0;
  end

  // ==========================================================================
  // One bus cycle: request held until ack is seen high, released at that edge
  // Host sets switch enables and clears flags only through these writes
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we  <= we;
    o_adr <= adr;
    o_sel <= 4'hF;
    o_dat <= dat;
    n = 0;
    // Bounded wait; ack is looked at on rising edges only, before it updates
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (i_ack !== 1'b1 && n < 20);
    if (i_ack !== 1'b1)
      n_tmo++;
    // Release at the very edge that sampled ack high
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_we  <= 1'b0;
    // Released data must not keep the last value
    o_dat <= ~dat;
  endtask
endmodule // bfs_host

/* File: dv/bfs_top_tb.sv */
// Self-checking bench for the bridge fault supervisor top.
// Assumes the host model in bfs_host.sv and the register map header.
`timescale 1ns/10ps
`include "bfs_regs.svh"
module bfs_top_tb;
  logic        I_CLOCK = 1'b0;
  logic        I_RESET = 1'b1;
  logic        supply_low = 1'b0;  // Logic supply below threshold
  logic        enable = 1'b1;      // Enable pin
  logic [7:0]  oc = 8'h00;         // Overcurrent pins, low side in upper half
  logic [7:0]  ol = 8'h00;         // Open-load pins, same layout
  logic [3:0]  glb = 4'h0;         // Prewarn, shutdown, undervolt, overvolt
  logic        wb_cyc, wb_stb, wb_we, ack, sleep;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat, rdat;
  logic [3:0]  hs_on, ls_on;
  wire  [7:0]  on = {ls_on, hs_on};
  logic [31:0] exp_q[$];           // Expected read data, oldest first
  int          n_errors = 0;
  int          check_count = 0;
  logic [7:0]  v, m;
  int          pos[4] = '{`BFS_GS_PREWARN, `BFS_GS_SHUTDOWN, `BFS_GS_UNDERVOLT, `BFS_GS_OVERVOLT};

  always #5 I_CLOCK = ~I_CLOCK;

  bfs_top u_bfs_top (
    .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_LOGIC_SUPPLY_LOW(supply_low),
    .I_ENABLE(enable), .I_HS_OVERCURRENT(oc[3:0]), .I_LS_OVERCURRENT(oc[7:4]),
    .I_HS_OPEN_LOAD(ol[3:0]), .I_LS_OPEN_LOAD(ol[7:4]),
    .I_THERMAL_PREWARN(glb[0]), .I_THERMAL_SHUTDOWN(glb[1]),
    .I_SUPPLY_UNDERVOLT(glb[2]), .I_SUPPLY_OVERVOLT(glb[3]),
    .I_WB_CYC(wb_cyc), .I_WB_STB(wb_stb), .I_WB_WE(wb_we), .I_WB_ADR(wb_adr),
    .I_WB_SEL(wb_sel), .I_WB_DAT(wb_dat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .O_HS_ON(hs_on), .O_LS_ON(ls_on), .O_SLEEP(sleep)
  );

  bfs_host u_bfs_host (
    .i_clk(I_CLOCK), .i_ack(ack), .o_cyc(wb_cyc), .o_stb(wb_stb), .o_we(wb_we),
    .o_adr(wb_adr), .o_sel(wb_sel), .o_dat(wb_dat)
  );

  // ==========================================================================
  // Shared checking and reporting
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Read answers are compared at the negedge, where ack and data have settled
  always @(negedge I_CLOCK)
  begin
    if (ack === 1'b1 && wb_we === 1'b0)
    begin
      if (exp_q.size() == 0)
        check("unexpected read", 32'h1, 32'h0);
      else
        check("read data", rdat, exp_q.pop_front());
    end
  end

  // ==========================================================================
  // Bus wrappers; a lost answer ends the run at once
  task automatic xfer_done;
    if (u_bfs_host.n_tmo != 0)
    begin
      n_errors++;
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_bfs_host.xfer(1'b1, a, d);
    xfer_done();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_bfs_host.xfer(1'b0, a, 32'h0);
    xfer_done();
  endtask

  // Pins pass two sync flops, a flag stage and the output register before reaching the switches
  task automatic settle;
    repeat (6) @(posedge I_CLOCK);
    #1;
  endtask

  initial
  begin
    repeat (20000) @(posedge I_CLOCK);
    n_errors++;
    results();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'hAFC5));
    m = 8'h01 << $urandom_range(7);
    v = 8'($urandom) | m;
    repeat (8) @(posedge I_CLOCK);
    I_RESET <= 1'b0;
    settle();
    check("sleep", 32'(sleep), 32'h0);
    check("switches", 32'(on), 32'h0);
    rd(`BFS_OFS_GLOBAL_STAT, 32'h0);
    rd(`BFS_OFS_ACT_CTRL, 32'h0);
    wr(`BFS_OFS_ACT_CTRL, 32'(v));
    rd(`BFS_OFS_ACT_CTRL, 32'(v));
    wr(8'h10, 32'hFF);
    rd(8'h10, 32'h0);
    wr(`BFS_OFS_GLOBAL_STAT, 32'h1);
    rd(`BFS_OFS_GLOBAL_STAT, 32'h1);
    settle();
    check("switches", 32'(on), 32'(v));
    // Overcurrent on one random switch, cleared while still present, then gone
    @(posedge I_CLOCK) oc <= m;
    settle();
    check("switches", 32'(on), 32'(v & ~m));
    rd(`BFS_OFS_OC_STAT, 32'(m));
    rd(`BFS_OFS_GLOBAL_STAT, 32'h41);
    wr(`BFS_OFS_OC_STAT, 32'(m));
    settle();
    rd(`BFS_OFS_OC_STAT, 32'(m));
    @(posedge I_CLOCK) oc <= 8'h00;
    settle();
    check("switches", 32'(on), 32'(v & ~m));
    rd(`BFS_OFS_ACT_CTRL, 32'(v));
    wr(`BFS_OFS_OC_STAT, 32'(m));
    wr(`BFS_OFS_GLOBAL_STAT, 32'h41);
    settle();
    check("switches", 32'(on), 32'(v));
    rd(`BFS_OFS_GLOBAL_STAT, 32'h1);
    // Open load on the same switch leaves the outputs alone
    @(posedge I_CLOCK) ol <= m;
    settle();
    check("switches", 32'(on), 32'(v));
    rd(`BFS_OFS_OL_STAT, 32'(m));
    rd(`BFS_OFS_GLOBAL_STAT, 32'h41);
    @(posedge I_CLOCK) ol <= 8'h00;
    // Let the pin drop pass the synchroniser, or the clear is overridden
    settle();
    wr(`BFS_OFS_OL_STAT, 32'(m));
    wr(`BFS_OFS_GLOBAL_STAT, 32'h41);
    rd(`BFS_OFS_OL_STAT, 32'h0);
    // Global faults: prewarn keeps outputs, the others cut all of them
    for (int k = 0; k < 4; k++)
    begin
      @(posedge I_CLOCK) glb <= 4'h1 << k;
      settle();
      check("switches", 32'(on), (k == 0) ? 32'(v) : 32'h0);
      rd(`BFS_OFS_GLOBAL_STAT, 32'h1 | (32'h1 << pos[k]));
      // Clearing while the fault persists must leave the flag set
      wr(`BFS_OFS_GLOBAL_STAT, 32'h1 << pos[k]);
      rd(`BFS_OFS_GLOBAL_STAT, 32'h1 | (32'h1 << pos[k]));
      @(posedge I_CLOCK) glb <= 4'h0;
      settle();
      check("switches", 32'(on), (k == 1) ? 32'h0 : 32'(v));
      rd(`BFS_OFS_GLOBAL_STAT, 32'h1 | (32'h1 << pos[k]));
      rd(`BFS_OFS_ACT_CTRL, 32'(v));
      wr(`BFS_OFS_GLOBAL_STAT, 32'h1 | (32'h1 << pos[k]));
      settle();
      check("switches", 32'(on), 32'(v));
      rd(`BFS_OFS_GLOBAL_STAT, 32'h1);
    end
    // Sleep through the enable pin clears everything and the indicator
    @(posedge I_CLOCK) enable <= 1'b0;
    settle();
    check("switches", 32'(on), 32'h0);
    check("sleep", 32'(sleep), 32'h1);
    @(posedge I_CLOCK) enable <= 1'b1;
    settle();
    rd(`BFS_OFS_GLOBAL_STAT, 32'h0);
    rd(`BFS_OFS_ACT_CTRL, 32'h0);
    // Low logic supply ignores the bus and holds outputs off
    wr(`BFS_OFS_ACT_CTRL, 32'(v));
    @(posedge I_CLOCK) supply_low <= 1'b1;
    settle();
    check("switches", 32'(on), 32'h0);
    check("sleep", 32'(sleep), 32'h1);
    wr(`BFS_OFS_ACT_CTRL, 32'hFF);
    @(posedge I_CLOCK) supply_low <= 1'b0;
    settle();
    rd(`BFS_OFS_ACT_CTRL, 32'h0);
    rd(`BFS_OFS_GLOBAL_STAT, 32'h0);
    settle();
    check("pending reads", 32'(exp_q.size()), 32'h0);
    results();
  end
endmodule // bfs_top_tb

/* File: rtl/bfs_flags.sv */
// Bank of sticky fault flags, write-one-to-clear from software.
// Assumes set and clear are single-cycle or level terms on the same clock.
`timescale 1ns/10ps
module bfs_flags #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,     // Clears every flag
  input  wire logic [W-1:0] i_set,     // Live fault detection
  input  wire logic [W-1:0] i_clr,     // Software clear request
  output logic      [W-1:0] o_flag
);

  // ========================================================================
  // One latch per flag; set beats clear so no event is lost
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_flag
      logic flag_q;   // Latched fault
      logic flag_d;

      // A persisting fault keeps the flag set through a clear
      always_comb
      begin
        flag_d = i_set[g] | (flag_q & ~i_clr[g]);
      end

      // Registers
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
          flag_q <= 1'b0;
        else
          flag_q <= flag_d;
      end

      assign o_flag[g] = flag_q;
    end
  endgenerate

endmodule // bfs_flags

/* File: rtl/bfs_pkg.sv */
// Types shared by the bridge fault supervisor files.
// Assumes nothing beyond a SystemVerilog compiler.
package bfs_pkg;

  // ========================================================================
  // Operating mode of the digital block
  typedef enum logic [1:0] {
    BFS_MODE_RESET,   // Logic supply low or power-on reset
    BFS_MODE_SLEEP,   // Enable pin low
    BFS_MODE_NORMAL   // Enable pin high, switches configurable
  } bfs_mode_t;

endpackage

/* File: rtl/bfs_regs.svh */
// Register map, field positions and reset values of the bridge fault supervisor.
// Assumes a 32-bit classic Wishbone slave with byte addresses on the address bus.
`ifndef BFS_REGS_SVH
`define BFS_REGS_SVH

// ==========================================================================
// Register byte offsets
`define BFS_OFS_ACT_CTRL      8'h00
`define BFS_OFS_GLOBAL_STAT   8'h04
`define BFS_OFS_OC_STAT       8'h08
`define BFS_OFS_OL_STAT       8'h0C

// ==========================================================================
// Field positions in the global status register
`define BFS_GS_RESET_IND      0
`define BFS_GS_PREWARN        1
`define BFS_GS_SHUTDOWN       2
`define BFS_GS_OVERVOLT       4
`define BFS_GS_UNDERVOLT      5
`define BFS_GS_LOAD_ERR       6

// Half-bridge n: high side at bit n, low side at bit n+4 of the other registers
`define BFS_LS_BASE           4

// ==========================================================================
// Reset values
`define BFS_RST_ACT_CTRL      8'h00
`define BFS_RST_FLAGS         8'h00

`endif

/* File: rtl/bfs_sync.sv */
// Two-flop synchroniser for a vector of unrelated level inputs.
// Assumes each bit is a slow level; no bus coherency between bits is needed.
`timescale 1ns/10ps
module bfs_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  // ========================================================================
  // Per-bit two-stage chain; only the second stage is read outside
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta_q;   // First stage, read only by the second
      logic meta_d;
      logic sync_q;   // Second stage, safe for logic
      logic sync_d;

      // Next values
      always_comb
      begin
        meta_d = i_async[g];
        sync_d = meta_q;
      end

      // Registers
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else
        begin
          meta_q <= meta_d;
          sync_q <= sync_d;
        end
      end

      assign o_sync[g] = sync_q;
    end
  endgenerate

endmodule // bfs_sync

/* File: rtl/bfs_top.sv */
// Top of the bridge fault supervisor: Wishbone registers, mode control,
// fault latching and gating of the four half-bridge switch commands.
// Assumes fault detector inputs are filtered levels from analog blocks.
`timescale 1ns/10ps
`include "bfs_regs.svh"
module bfs_top #(
  parameter int NB = 4   // Half-bridges
) (
  input  wire logic          I_CLOCK,
  input  wire logic          I_RESET,          // Logic power-on reset
  input  wire logic          I_LOGIC_SUPPLY_LOW,
  input  wire logic          I_ENABLE,
  input  wire logic [NB-1:0] I_HS_OVERCURRENT,
  input  wire logic [NB-1:0] I_LS_OVERCURRENT,
  input  wire logic [NB-1:0] I_HS_OPEN_LOAD,
  input  wire logic [NB-1:0] I_LS_OPEN_LOAD,
  input  wire logic          I_THERMAL_PREWARN,
  input  wire logic          I_THERMAL_SHUTDOWN,
  input  wire logic          I_SUPPLY_UNDERVOLT,
  input  wire logic          I_SUPPLY_OVERVOLT,
  input  wire logic          I_WB_CYC,
  input  wire logic          I_WB_STB,
  input  wire logic          I_WB_WE,
  input  wire logic [7:0]    I_WB_ADR,
  input  wire logic [3:0]    I_WB_SEL,
  input  wire logic [31:0]   I_WB_DAT,
  output logic      [31:0]   O_WB_DAT,
  output logic               O_WB_ACK,
  output logic      [NB-1:0] O_HS_ON,          // High = switch driven
  output logic      [NB-1:0] O_LS_ON,
  output logic               O_SLEEP
);

  localparam int SW = 2 * NB;   // Switches in total
  localparam int PW = 2 + 4 * NB;

  // ========================================================================
  // Pin synchronisation: everything outside arrives asynchronously
  logic [PW+3:0] sync_s;        // Synchronised pin levels
  logic          supply_low_s;  // Logic supply below threshold
  logic          en_s;          // Enable pin
  logic [SW-1:0] oc_s;          // Overcurrent detections, HS low half
  logic [SW-1:0] ol_s;          // Open-load detections
  logic          tpw_s;
  logic          tsd_s;
  logic          uv_s;
  logic          ov_s;

  bfs_sync #(.W(PW + 4)) u_sync (
    .i_clk   (I_CLOCK),
    .i_rst   (I_RESET),
    .i_async ({I_LOGIC_SUPPLY_LOW, I_ENABLE, I_LS_OVERCURRENT, I_HS_OVERCURRENT,
               I_LS_OPEN_LOAD, I_HS_OPEN_LOAD, I_THERMAL_PREWARN,
               I_THERMAL_SHUTDOWN, I_SUPPLY_UNDERVOLT, I_SUPPLY_OVERVOLT}),
    .o_sync  (sync_s)
  );

  assign {supply_low_s, en_s, oc_s, ol_s, tpw_s, tsd_s, uv_s, ov_s} = sync_s;

  // ========================================================================
  // Mode control
  bfs_pkg::bfs_mode_t mode_q;   // Current mode
  bfs_pkg::bfs_mode_t mode_d;
  logic               rst_int;  // Clears every register bank

  // Internal reset covers power-on, logic undervoltage and sleep
  assign rst_int = I_RESET | supply_low_s | ~en_s;

  // Next mode follows the supply and enable levels
  always_comb
  begin
    case (mode_q)
      bfs_pkg::BFS_MODE_RESET,
      bfs_pkg::BFS_MODE_SLEEP,
      bfs_pkg::BFS_MODE_NORMAL:
      begin
        if (supply_low_s)
          mode_d = bfs_pkg::BFS_MODE_RESET;
        else if (!en_s)
          mode_d = bfs_pkg::BFS_MODE_SLEEP;
        else
          mode_d = bfs_pkg::BFS_MODE_NORMAL;
      end
      default:
        mode_d = bfs_pkg::BFS_MODE_RESET;
    endcase
  end

  // Mode register
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
      mode_q <= bfs_pkg::BFS_MODE_RESET;
    else
      mode_q <= mode_d;
  end

  // ========================================================================
  // Wishbone request decode
  logic ack_q;     // Answer, one cycle after the request
  logic ack_d;
  logic req;       // New request this cycle
  logic wr;        // Accepted write, low byte enabled
  logic wr_act;
  logic wr_gs;
  logic wr_oc;
  logic wr_ol;

  // Writes are dropped while the logic is held in reset
  assign req    = I_WB_CYC & I_WB_STB & ~ack_q;
  assign wr     = req & I_WB_WE & I_WB_SEL[0] & ~rst_int;
  assign wr_act = wr & (I_WB_ADR == `BFS_OFS_ACT_CTRL);
  assign wr_gs  = wr & (I_WB_ADR == `BFS_OFS_GLOBAL_STAT);
  assign wr_oc  = wr & (I_WB_ADR == `BFS_OFS_OC_STAT);
  assign wr_ol  = wr & (I_WB_ADR == `BFS_OFS_OL_STAT);

  // ========================================================================
  // Bridge activation control and reset indicator
  logic [SW-1:0] act_q;   // Switch enables, HS in low half
  logic [SW-1:0] act_d;
  logic          ind_q;   // Reset indicator, 0 after any reset
  logic          ind_d;

  // Supply undervolt and overvolt never touch these, so operation resumes by itself
  always_comb
  begin
    act_d = act_q;
    ind_d = ind_q;
    if (wr_act)
      act_d = I_WB_DAT[SW-1:0];
    if (wr_gs && I_WB_DAT[`BFS_GS_RESET_IND])
      ind_d = 1'b1;                                      // Host marks reset seen
  end

  // Registers; sleep and logic undervoltage restore reset values
  always_ff @(posedge I_CLOCK)
  begin
    if (rst_int)
    begin
      act_q <= SW'(`BFS_RST_ACT_CTRL);
      ind_q <= 1'b0;
    end
    else
    begin
      act_q <= act_d;
      ind_q <= ind_d;
    end
  end

  // ========================================================================
  // Fault flags: {load err, undervolt, overvolt, shutdown, prewarn}, OC, OL
  logic [4:0]    gf_set;
  logic [4:0]    gf_clr;
  logic [4:0]    gf_q;
  logic [SW-1:0] oc_q;
  logic [SW-1:0] ol_q;

  // Load error summary follows any switch-level fault
  assign gf_set = {(|oc_s) | (|ol_s), uv_s, ov_s, tsd_s, tpw_s};
  // Only a host write or the internal reset clears; nothing else touches the prewarn flag
  assign gf_clr = wr_gs ? {I_WB_DAT[`BFS_GS_LOAD_ERR], I_WB_DAT[`BFS_GS_UNDERVOLT],
                           I_WB_DAT[`BFS_GS_OVERVOLT], I_WB_DAT[`BFS_GS_SHUTDOWN],
                           I_WB_DAT[`BFS_GS_PREWARN]} : 5'h00;

  bfs_flags #(.W(5)) u_gflags (
    .i_clk  (I_CLOCK),
    .i_rst  (rst_int),
    .i_set  (gf_set),
    .i_clr  (gf_clr),
    .o_flag (gf_q)
  );

  bfs_flags #(.W(SW)) u_ocflags (
    .i_clk  (I_CLOCK),
    .i_rst  (rst_int),
    .i_set  (oc_s),
    .i_clr  (wr_oc ? I_WB_DAT[SW-1:0] : '0),
    .o_flag (oc_q)
  );

  bfs_flags #(.W(SW)) u_olflags (
    .i_clk  (I_CLOCK),
    .i_rst  (rst_int),
    .i_set  (ol_s),
    .i_clr  (wr_ol ? I_WB_DAT[SW-1:0] : '0),
    .o_flag (ol_q)
  );

  // ========================================================================
  // Output gating; open load and prewarn deliberately do not appear here
  logic [SW-1:0] on_q;    // Registered switch commands
  logic [SW-1:0] on_d;
  logic          sleep_q;
  logic          sleep_d;

  // Overcurrent blocks its own switch, shutdown latches all off, supply
  // faults block all only while present
  always_comb
  begin
    on_d    = act_q & ~oc_q;
    // Shutdown flag sits at index 1 of the global bank; overvolt (index 2)
    // must gate only through its live level so the outputs recover by themselves
    if (gf_q[1] || uv_s || ov_s || rst_int)
      on_d  = '0;
    sleep_d = (mode_d != bfs_pkg::BFS_MODE_NORMAL);
  end

  // Output registers
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      on_q    <= '0;
      sleep_q <= 1'b1;
    end
    else
    begin
      on_q    <= on_d;
      sleep_q <= sleep_d;
    end
  end

  assign O_HS_ON = on_q[NB-1:0];
  assign O_LS_ON = on_q[SW-1:NB];
  assign O_SLEEP = sleep_q;

  // ========================================================================
  // Wishbone answer: ack one cycle after request, unmapped reads give zero
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [7:0]  gs_view;   // Global status as software sees it

  assign gs_view = {1'b0, gf_q[4], gf_q[3], gf_q[2], 1'b0, gf_q[1], gf_q[0], ind_q};

  // Read mux; the bank reads zero while held in reset
  always_comb
  begin
    ack_d  = req;
    rdat_d = 32'h0000_0000;
    if (req && !I_WB_WE && !rst_int)
    begin
      case (I_WB_ADR)
        `BFS_OFS_ACT_CTRL:    rdat_d = {{(32-SW){1'b0}}, act_q};
        `BFS_OFS_GLOBAL_STAT: rdat_d = {24'h000000, gs_view};
        `BFS_OFS_OC_STAT:     rdat_d = {{(32-SW){1'b0}}, oc_q};
        `BFS_OFS_OL_STAT:     rdat_d = {{(32-SW){1'b0}}, ol_q};
        default:              rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rdat_q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);

  sequence s_enable_dropped;
    !en_s ##1 en_s;
  endsequence

  property p_por_clears;
    $fell(rst_int) |-> (act_q == '0) && (on_q == '0) && !ind_q;
  endproperty
  a_por_clears: assert property (p_por_clears) else $error("reset left state set");

  property p_normal_drive;
    (!rst_int && !uv_s && !ov_s && gf_q[1] == 1'b0 && oc_q == '0 && act_q != '0)
      ##1 !rst_int |-> on_q == $past(act_q);
  endproperty
  a_normal_drive: assert property (p_normal_drive) else $error("enabled switch not on");

  property p_sleep;
    !en_s |=> (on_q == '0) && (act_q == '0) && sleep_q;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep left outputs on");

  property p_supply_low;
    supply_low_s && req |=> (rdat_q == 32'h0000_0000) && (act_q == '0);
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("bus served in reset");

  property p_ind_zero;
    rst_int |=> !ind_q;
  endproperty
  a_ind_zero: assert property (p_ind_zero) else $error("indicator set after reset");

  property p_en_reset_ind;
    s_enable_dropped |-> !ind_q;
  endproperty
  a_en_reset_ind: assert property (p_en_reset_ind) else $error("enable reset not shown");

  property p_vs_keeps;
    (uv_s || ov_s) && !rst_int && !wr_act ##1 !rst_int |-> $stable(act_q);
  endproperty
  a_vs_keeps: assert property (p_vs_keeps) else $error("supply fault lost enables");

  property p_load_err;
    ((|oc_s) || (|ol_s)) && !rst_int |=> gf_q[4];
  endproperty
  a_load_err: assert property (p_load_err) else $error("load error not latched");

  property p_oc_off;
    oc_q != '0 |=> (on_q & $past(oc_q)) == '0;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("overcurrent switch still on");

  property p_ol_latch;
    !rst_int ##1 !rst_int |-> ($past(ol_s) & ~ol_q) == '0;
  endproperty
  a_ol_latch: assert property (p_ol_latch) else $error("open load not latched");

  property p_tpw_latch;
    tpw_s && !rst_int |=> gf_q[0];
  endproperty
  a_tpw_latch: assert property (p_tpw_latch) else $error("prewarn not latched");

  property p_tsd_off;
    gf_q[1] |=> on_q == '0;
  endproperty
  a_tsd_off: assert property (p_tsd_off) else $error("shutdown left outputs on");

  property p_uv_off;
    uv_s && !rst_int |=> (on_q == '0) && gf_q[3];
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("undervolt not handled");

  property p_ov_off;
    ov_s && !rst_int |=> (on_q == '0) && gf_q[2];
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("overvolt not handled");

  property p_tpw_hold;
    gf_q[0] && !rst_int && !gf_clr[0] |=> gf_q[0];
  endproperty
  a_tpw_hold: assert property (p_tpw_hold) else $error("prewarn cleared by itself");

  property p_reeval;
    wr_gs && tsd_s |=> gf_q[1];
  endproperty
  a_reeval: assert property (p_reeval) else $error("persisting fault lost");

endmodule // bfs_top
